// >>> design/ext_line_defines.svh
/*
  Offsets, field masks, reset values and widths for the external line
  pending-flag block.
  Assumes a 32-bit APB register bus with one aligned word per register.
*/
`ifndef EXT_LINE_DEFINES_SVH
`define EXT_LINE_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define EXT_OFF_IMASK 12'h000
`define EXT_OFF_EMASK 12'h004
`define EXT_OFF_RTEN 12'h008
`define EXT_OFF_FTEN 12'h00C
`define EXT_OFF_SWTRIG 12'h010
`define EXT_OFF_PEND 12'h014

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
// Implemented lines: bits 17..0, 19, 22..21
`define EXT_LINE_MASK 32'h006BFFFF
`define EXT_RESET_VAL 32'h00000000
`define EXT_ADDR_W 12

`endif

// >>> design/ext_line_pkg.sv
/*
  Types shared by the external line pending-flag block.
  Assumes ext_line_defines.svh is compiled alongside for the constants.
*/
package ext_line_pkg;

  // Edge pulses for all 32 line positions, one cycle each
  typedef struct packed {
    logic [31:0] rise;
    logic [31:0] fall;
  } line_events_t;

  // Register selected by the current APB address
  typedef enum logic [2:0] {
    SEL_IMASK,
    SEL_EMASK,
    SEL_RTEN,
    SEL_FTEN,
    SEL_SWTRIG,
    SEL_PEND,
    SEL_NONE
  } reg_sel_t;

endpackage

// >>> design/line_edge_detect.sv
/*
  Edge detector for the external interrupt lines.
  Assumes the lines are already synchronous to pclk and glitch free.
*/
`timescale 1ns/1ns
`include "ext_line_defines.svh"

module line_edge_detect (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Lines and edge pulses
  input wire logic [31:0] lines,
  output ext_line_pkg::line_events_t ev
);

  logic [31:0] prev_r;
  logic armed_r;

  // The first cycle after reset only captures the lines, so a line that is
  // already high at reset release is not mistaken for a rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= `EXT_RESET_VAL;
      armed_r <= 1'b0;
    end else begin
      prev_r <= lines;
      armed_r <= 1'b1;
    end
  end

  // Pulses last exactly one cycle per edge; one driver for the whole struct
  wire [31:0] rise_w = lines & ~prev_r;
  wire [31:0] fall_w = ~lines & prev_r;
  assign ev = armed_r ? {rise_w, fall_w} : 64'h0000000000000000;

endmodule

// >>> design/ext_line_pending_flags.sv
/*
  Pending flags of the external line interrupt and event controller, with
  its edge enables, software trigger and masks, on an APB slave.
  Assumes synchronous, glitch-free external lines and an APB4 master.
*/
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ns
`include "ext_line_defines.svh"

module ext_line_pending_flags (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`EXT_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External lines
  input wire logic [31:0] lines,
  // Interrupt and event requests
  output logic irq,
  output logic evt
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [31:0] imask_r, emask_r, rten_r, ften_r, swt_r, pend_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r, irq_r, evt_r;
  ext_line_pkg::line_events_t ev;
  ext_line_pkg::reg_sel_t sel;

  // Merge a write into a register by byte strobes, dropping reserved bits
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] bm;
    bm = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge = ((old & ~bm) | (wd & bm)) & `EXT_LINE_MASK;
  endfunction

  line_edge_detect u_edges (
    .pclk(pclk),
    .presetn(presetn),
    .lines(lines),
    .ev(ev)
  );

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  always_comb begin
    if (paddr == `EXT_OFF_IMASK) begin
      sel = ext_line_pkg::SEL_IMASK;
    end else if (paddr == `EXT_OFF_EMASK) begin
      sel = ext_line_pkg::SEL_EMASK;
    end else if (paddr == `EXT_OFF_RTEN) begin
      sel = ext_line_pkg::SEL_RTEN;
    end else if (paddr == `EXT_OFF_FTEN) begin
      sel = ext_line_pkg::SEL_FTEN;
    end else if (paddr == `EXT_OFF_SWTRIG) begin
      sel = ext_line_pkg::SEL_SWTRIG;
    end else if (paddr == `EXT_OFF_PEND) begin
      sel = ext_line_pkg::SEL_PEND;
    end else begin
      sel = ext_line_pkg::SEL_NONE;
    end
  end

  // Setup phase samples read data; the write lands at the completing edge
  wire setup = psel && !penable;
  wire wr = psel && penable && pready_r && pwrite && !pslverr_r;
  wire wr_imask = wr && (sel == ext_line_pkg::SEL_IMASK);
  wire wr_emask = wr && (sel == ext_line_pkg::SEL_EMASK);
  wire wr_rten = wr && (sel == ext_line_pkg::SEL_RTEN);
  wire wr_ften = wr && (sel == ext_line_pkg::SEL_FTEN);
  wire wr_swt = wr && (sel == ext_line_pkg::SEL_SWTRIG);
  wire wr_pend = wr && (sel == ext_line_pkg::SEL_PEND);

  wire [31:0] rten_new = merge(rten_r, pwdata, pstrb);
  wire [31:0] ften_new = merge(ften_r, pwdata, pstrb);
  wire [31:0] swt_new = merge(swt_r, pwdata, pstrb);
  wire [31:0] wbytes = merge(32'h00000000, pwdata, pstrb);

  // ----------------------------------------------------------------
  // Pending flag next state
  // ----------------------------------------------------------------
  // Either enabled edge sets the flag, so both may be enabled at once
  wire [31:0] hw_set = ((ev.rise & rten_r) | (ev.fall & ften_r)) & `EXT_LINE_MASK;
  // Lines whose edge selection a write changes lose their flag
  wire [31:0] pol_clr = wr_rten ? (rten_r ^ rten_new) :
                        wr_ften ? (ften_r ^ ften_new) : 32'h00000000;
  // A trigger bit going from zero to one raises the flag
  wire [31:0] sw_set = wr_swt ? (swt_new & ~swt_r) : 32'h00000000;
  // Only ones in implemented positions clear; zeros and reserved bits do not
  wire [31:0] w1c = wr_pend ? wbytes : 32'h00000000;
  // Set beats write-one-clear; an edge seen during a polarity rewrite is
  // deliberately dropped, as the line's selection is in flux
  wire [31:0] pend_nxt = (pend_r & ~(w1c | pol_clr)) | (hw_set & ~pol_clr) | sw_set;
  // Trigger bits fall together with their flags
  wire [31:0] swt_nxt = (wr_swt ? swt_new : swt_r) & pend_nxt;
  wire irq_nxt = |(pend_nxt & imask_r);
  wire evt_nxt = |(pend_nxt & emask_r);

  // Read mux
  wire [31:0] rd_val = (sel == ext_line_pkg::SEL_IMASK) ? imask_r :
                       (sel == ext_line_pkg::SEL_EMASK) ? emask_r :
                       (sel == ext_line_pkg::SEL_RTEN) ? rten_r :
                       (sel == ext_line_pkg::SEL_FTEN) ? ften_r :
                       (sel == ext_line_pkg::SEL_SWTRIG) ? swt_r :
                       (sel == ext_line_pkg::SEL_PEND) ? pend_r : 32'h00000000;

  // ----------------------------------------------------------------
  // Bus response registers
  // ----------------------------------------------------------------
  // One wait-free access phase: pready rises for exactly the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= `EXT_RESET_VAL;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup && (sel == ext_line_pkg::SEL_NONE);
      if (setup) begin
        prdata_r <= pwrite ? 32'h00000000 : rd_val;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask_r <= `EXT_RESET_VAL;
      emask_r <= `EXT_RESET_VAL;
      rten_r <= `EXT_RESET_VAL;
      ften_r <= `EXT_RESET_VAL;
    end else begin
      if (wr_imask) imask_r <= merge(imask_r, pwdata, pstrb);
      if (wr_emask) emask_r <= merge(emask_r, pwdata, pstrb);
      if (wr_rten) rten_r <= rten_new;
      if (wr_ften) ften_r <= ften_new;
    end
  end

  // Flags and request outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= `EXT_RESET_VAL;
      swt_r <= `EXT_RESET_VAL;
      irq_r <= 1'b0;
      evt_r <= 1'b0;
    end else begin
      pend_r <= pend_nxt;
      swt_r <= swt_nxt;
      irq_r <= irq_nxt;
      evt_r <= evt_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  assign evt = evt_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Both edges enabled on a line, and one of them arrives
  sequence both_enabled_edge;
    (((rten_r & ften_r & (ev.rise | ev.fall)) & `EXT_LINE_MASK) != 32'h00000000) && !wr;
  endsequence

  sequence pend_read_setup;
    setup && !pwrite && (sel == ext_line_pkg::SEL_PEND);
  endsequence

  reserved_flags_zero_a: assert property ((pend_r & ~`EXT_LINE_MASK) == 32'h00000000)
    else $error("pending flag set in a reserved position");

  pend_read_value_a: assert property (pend_read_setup ##1 (penable && pready_r)
    |-> prdata_r == $past(pend_r))
    else $error("pending read does not return the flags");

  hw_edge_set_a: assert property ((hw_set != 32'h00000000) && !wr |=> (pend_r & $past(hw_set)) == $past(hw_set))
    else $error("enabled edge did not set its flag");

  w1c_clears_a: assert property (wr_pend |=> (pend_r & $past(w1c & ~hw_set)) == 32'h00000000)
    else $error("write of one did not clear the flag");

  polarity_clear_a: assert property ((pol_clr != 32'h00000000) |=> (pend_r & $past(pol_clr)) == 32'h00000000)
    else $error("polarity change did not clear the flag");

  sw_trigger_set_a: assert property (wr_swt && (sw_set != 32'h00000000)
    |=> ((pend_r & swt_r & $past(sw_set)) == $past(sw_set)))
    else $error("software trigger did not set flag and trigger bit");

  sw_trigger_drop_a: assert property ((swt_r & ~pend_r) == 32'h00000000)
    else $error("trigger bit outlived its pending flag");

  irq_gated_a: assert property ((irq == ((pend_r & $past(imask_r)) != 32'h00000000))
    && (evt == ((pend_r & $past(emask_r)) != 32'h00000000)))
    else $error("interrupt or event output disagrees with masked flags");

  either_edge_a: assert property (both_enabled_edge |=> (pend_r & $past(rten_r & ften_r & (ev.rise | ev.fall)
    & `EXT_LINE_MASK)) != 32'h00000000)
    else $error("edge ignored with both edges enabled");

  zero_write_keeps_a: assert property (wr_pend && (w1c == 32'h00000000) && (hw_set == 32'h00000000)
    |=> $stable(pend_r))
    else $error("write of zero disturbed the flags");

endmodule

// >>> tb/ext_lines_model.sv
/*
  Model of the external lines that feed the pending-flag block.
  Assumes the bench sets the wanted levels; lines move just after pclk.
*/
`timescale 1ns/1ns

module ext_lines_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Wanted levels and driven lines
  input wire logic [31:0] want,
  output logic [31:0] lines
);
  // --------------------------------
  // Line drive
  // --------------------------------
  // Registered so each change is one clean synchronous edge, never a glitch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lines <= 32'h00000000;
    end else begin
      lines <= want;
    end
  end
endmodule

// >>> tb/ext_line_pending_flags_tb_top.sv
/*
  Self-checking bench for the pending-flag block: APB accesses, line edges,
  masks, software trigger and an unmapped address.
  Assumes the design files and their package are compiled first.
*/
`timescale 1ns/1ns
`include "ext_line_defines.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end

module ext_line_pending_flags_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, evt, bad;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, lines, want, rd;
  logic [3:0] pstrb;
  int err_count, comparisons, cycles;

  ext_line_pending_flags dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lines(lines), .irq(irq), .evt(evt));
  ext_lines_model far (.pclk(pclk), .presetn(presetn), .want(want), .lines(lines));

  // --------------------------------
  // Clock and timeout
  // --------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // The run needs well under 1000 cycles, so 3000 means a hang
  initial begin
    forever begin
      @(posedge pclk);
      cycles++;
      if (cycles > 3000) begin
        err_count++;
        give_verdict();
      end
    end
  end

  // --------------------------------
  // APB master tasks
  // --------------------------------
  // Request held until pready is seen high at an edge, then released
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    `CHK(pready, 1'b1)
    rd = prdata;
    bad = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000, 4'hF);
    `CHK(rd, e)
    `CHK(bad, 1'b0)
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // --------------------------------
  // Test sequence
  // --------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
    want = 32'h00000000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`EXT_OFF_PEND, 32'h00000000);
    wr(`EXT_OFF_RTEN, 32'hFFFFFFFF);
    rdchk(`EXT_OFF_RTEN, `EXT_LINE_MASK);
    $display("test reset and layout done");
    // Rising on 0, 22 and reserved 18, 20; falling on 21, 22; line 1 not enabled
    wr(`EXT_OFF_RTEN, 32'h00540001);
    wr(`EXT_OFF_FTEN, 32'h00600000);
    want <= 32'h00740003;
    repeat (3) @(posedge pclk);
    rdchk(`EXT_OFF_PEND, 32'h00400001);
    wr(`EXT_OFF_PEND, 32'h00400000);
    rdchk(`EXT_OFF_PEND, 32'h00000001);
    want <= 32'h00000000;
    repeat (3) @(posedge pclk);
    rdchk(`EXT_OFF_PEND, 32'h00600001);
    $display("test edges done");
    // Masks open one line each; evt must stay low until its own mask opens
    wr(`EXT_OFF_IMASK, 32'h00000001);
    repeat (3) @(posedge pclk);
    `CHK(irq, 1'b1)
    `CHK(evt, 1'b0)
    wr(`EXT_OFF_EMASK, 32'h00200000);
    repeat (3) @(posedge pclk);
    `CHK(evt, 1'b1)
    // Zeros and reserved ones change nothing; a disabled byte lane clears nothing
    wr(`EXT_OFF_PEND, 32'hFF900000);
    rdchk(`EXT_OFF_PEND, 32'h00600001);
    apb(1'b1, `EXT_OFF_PEND, 32'h00600001, 4'hB);
    rdchk(`EXT_OFF_PEND, 32'h00600000);
    repeat (3) @(posedge pclk);
    `CHK(irq, 1'b0)
    $display("test masks and clearing done");
    // Dropping falling detection on line 21 clears its flag, so evt falls
    wr(`EXT_OFF_FTEN, 32'h00400000);
    rdchk(`EXT_OFF_PEND, 32'h00400000);
    repeat (3) @(posedge pclk);
    `CHK(evt, 1'b0)
    wr(`EXT_OFF_SWTRIG, 32'h00080008);
    rdchk(`EXT_OFF_PEND, 32'h00480008);
    wr(`EXT_OFF_PEND, 32'h00000008);
    rdchk(`EXT_OFF_SWTRIG, 32'h00080000);
    rdchk(`EXT_OFF_PEND, 32'h00480000);
    // Dropping rising detection on line 22 clears its flag only
    wr(`EXT_OFF_RTEN, 32'h00000001);
    rdchk(`EXT_OFF_PEND, 32'h00080000);
    apb(1'b0, 12'h018, 32'h00000000, 4'hF);
    `CHK(bad, 1'b1)
    apb(1'b1, 12'h018, 32'hFFFFFFFF, 4'hF);
    `CHK(bad, 1'b1)
    rdchk(`EXT_OFF_PEND, 32'h00080000);
    $display("test polarity, trigger and unmapped done");
    give_verdict();
  end
endmodule
